/* src/sbas_pkg.sv */
package sbas_pkg;
  // Register byte addresses
  localparam logic [11:0] SBAS_CTRL_ADDR = 12'h000;
  localparam logic [11:0] SBAS_STAT_ADDR = 12'h004;
  localparam logic [11:0] SBAS_MON_ADDR = 12'h008;
  localparam logic [11:0] SBAS_CFG_ADDR = 12'h00C;
  // Control fields
  localparam int SBAS_CTRL_REQ_BIT = 0;
  localparam int SBAS_CTRL_LOCK_BIT = 1;
  localparam int SBAS_CTRL_ERR_BIT = 2;
  localparam int SBAS_CTRL_RDY_BIT = 3;
  localparam int SBAS_CTRL_BSEL_LSB = 4;
  localparam int SBAS_CTRL_STALL_BIT = 6;
  // Status fields
  localparam int SBAS_STAT_OWN_BIT = 0;
  localparam int SBAS_STAT_BUS_INIT_N_BIT = 1;
  localparam int SBAS_STAT_PRI_BIT = 2;
  localparam int SBAS_STAT_BNR_BIT = 3;
  localparam int SBAS_STAT_PROBE_REQUEST_N_BIT = 4;
  localparam int SBAS_STAT_AGENT0_BIT = 5;
  localparam int SBAS_STAT_ISSUE_BIT = 6;
  localparam int SBAS_STAT_DBG_BIT = 7;
  // Config fields
  localparam int SBAS_CFG_DRV_BIT = 0;
  localparam int SBAS_CFG_OBS_BIT = 1;
  // Reset values
  localparam logic [1:0] SBAS_BSEL_RST = 2'h0;
  localparam logic [3:0] SBAS_MON_RST = 4'h0;
  // Bus-init pulse length in bus clocks
  localparam int SBAS_BUS_INIT_N_CYC = 2;
  typedef enum logic [2:0] {
    SBAS_ARB_IDLE = 3'b001,
    SBAS_ARB_REQ = 3'b010,
    SBAS_ARB_OWN = 3'b100
  } sbas_arb_e;
endpackage

/* src/sbas_top.sv */
// Functional notes
// - If driver option enabled, assert bus-init when software writes the control error bit.
// - If observation enabled and bus-init seen, reset lock and arbitration state.
// - Agent unable to accept assert stall; owner issues nothing during stall.
// - Drive four breakpoint/monitor outputs (lines 0-3) for breakpoints and performance counters.
// - Monitor line 4 is probe-ready output showing debug readiness.
// - Monitor line 5 is probe-request input; device acts on it.
// - Request bus on symmetric request pin; sample it at reset for agent zero.
// - Drive two bus-select outputs choosing input clock frequency.
`timescale 1ns/1ps
module sbas_top
  import sbas_pkg::*;
#(
  parameter int MON_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cfg_bus_init_n_drive_en,
  input wire logic cfg_bus_init_n_observe_en,
  input wire logic bus_init_n_in,
  output logic bus_init_n_out,
  output logic bus_init_n_oe,
  input wire logic block_next_request_n_in,
  output logic block_next_request_n_out,
  output logic block_next_request_n_oe,
  input wire logic priority_agent_request_n,
  input wire logic symmetric_request_n_in,
  output logic symmetric_request_n_out,
  output logic symmetric_request_n_oe,
  input wire logic bus_grant_idle,
  output logic txn_issue,
  input wire logic [MON_W-1:0] breakpoint_monitor_n_in,
  output logic [MON_W-1:0] breakpoint_monitor_n_out,
  output logic [MON_W-1:0] breakpoint_monitor_n_oe,
  output logic debug_mode,
  output logic [1:0] bus_frequency_select
);
  // Lines 4 and 5 carry fixed probe roles, so only six lines can be served
  if (MON_W != 6) begin : g_mon_width_chk
    $error("sbas_top: monitor width must be 6");
  end

  // Three-stage sync; a change counts once stages 2 and 3 agree
  logic [2:0] s_bus_init_n, s_bnr, s_pri, s_probe_request_n;
  logic bus_init_n_q, bnr_q, pri_q, probe_request_n_q;
  logic next_bus_init_n_q, next_bnr_q, next_pri_q, next_probe_request_n_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_bus_init_n <= 3'h7;
      s_bnr <= 3'h7;
      s_pri <= 3'h7;
      s_probe_request_n <= 3'h7;
      bus_init_n_q <= 1'b0;
      bnr_q <= 1'b0;
      pri_q <= 1'b0;
      probe_request_n_q <= 1'b0;
    end else if (clk_en) begin
      s_bus_init_n <= {s_bus_init_n[1:0], bus_init_n_in};
      s_bnr <= {s_bnr[1:0], block_next_request_n_in};
      s_pri <= {s_pri[1:0], priority_agent_request_n};
      s_probe_request_n <= {s_probe_request_n[1:0], breakpoint_monitor_n_in[5]};
      bus_init_n_q <= next_bus_init_n_q;
      bnr_q <= next_bnr_q;
      pri_q <= next_pri_q;
      probe_request_n_q <= next_probe_request_n_q;
    end
  end
  always_comb begin
    next_bus_init_n_q = (s_bus_init_n[2] == s_bus_init_n[1]) ? !s_bus_init_n[2] : bus_init_n_q;
    next_bnr_q = (s_bnr[2] == s_bnr[1]) ? !s_bnr[2] : bnr_q;
    next_pri_q = (s_pri[2] == s_pri[1]) ? !s_pri[2] : pri_q;
    next_probe_request_n_q = (s_probe_request_n[2] == s_probe_request_n[1]) ? !s_probe_request_n[2] : probe_request_n_q;
  end

  // Power-on capture: one cycle after reset release, then frozen
  logic cfg_done, drv_en, obs_en, agent0;
  logic next_cfg_done, next_drv_en, next_obs_en, next_agent0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done <= 1'b0;
      drv_en <= 1'b0;
      obs_en <= 1'b0;
      agent0 <= 1'b0;
    end else if (clk_en) begin
      cfg_done <= next_cfg_done;
      drv_en <= next_drv_en;
      obs_en <= next_obs_en;
      agent0 <= next_agent0;
    end
  end
  always_comb begin
    next_cfg_done = 1'b1;
    // Straps are static through configuration, so no synchroniser delays the capture
    next_drv_en = cfg_done ? drv_en : cfg_bus_init_n_drive_en;
    next_obs_en = cfg_done ? obs_en : cfg_bus_init_n_observe_en;
    // Pin low at capture selects agent zero
    next_agent0 = cfg_done ? agent0 : !symmetric_request_n_in;
  end

  // Registers
  logic ctl_req, ctl_lock, ctl_err, ctl_rdy, ctl_stall;
  logic [1:0] ctl_bsel;
  logic [3:0] mon_out;
  logic next_ctl_req, next_ctl_lock, next_ctl_err, next_ctl_rdy, next_ctl_stall;
  logic [1:0] next_ctl_bsel;
  logic [3:0] next_mon_out;
  logic [31:0] next_prdata;
  logic next_pslverr, next_pready;
  logic bus_init_n_seen, next_bus_init_n_seen;
  logic [1:0] bus_init_n_cnt, next_bus_init_n_cnt;
  sbas_arb_e arb, next_arb;
  logic dbg, next_dbg;
  logic issue, next_issue;
  logic wr, rd, hit;
  // Access taken on the first access-phase edge; pready follows in the next cycle
  assign wr = psel && penable && pwrite && !pready;
  assign rd = psel && penable && !pwrite && !pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_req <= 1'b0;
      ctl_lock <= 1'b0;
      ctl_err <= 1'b0;
      ctl_rdy <= 1'b0;
      ctl_stall <= 1'b0;
      ctl_bsel <= SBAS_BSEL_RST;
      mon_out <= SBAS_MON_RST;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
      bus_init_n_seen <= 1'b0;
      bus_init_n_cnt <= 2'h0;
      arb <= SBAS_ARB_IDLE;
      dbg <= 1'b0;
      issue <= 1'b0;
    end else if (clk_en) begin
      ctl_req <= next_ctl_req;
      ctl_lock <= next_ctl_lock;
      ctl_err <= next_ctl_err;
      ctl_rdy <= next_ctl_rdy;
      ctl_stall <= next_ctl_stall;
      ctl_bsel <= next_ctl_bsel;
      mon_out <= next_mon_out;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= next_pready;
      bus_init_n_seen <= next_bus_init_n_seen;
      bus_init_n_cnt <= next_bus_init_n_cnt;
      arb <= next_arb;
      dbg <= next_dbg;
      issue <= next_issue;
    end
  end

  always_comb begin
    hit = 1'b1;
    next_ctl_req = ctl_req;
    next_ctl_lock = ctl_lock;
    next_ctl_err = 1'b0;
    next_ctl_rdy = ctl_rdy;
    next_ctl_stall = ctl_stall;
    next_ctl_bsel = ctl_bsel;
    next_mon_out = mon_out;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_pready = psel && penable && !pready;
    next_bus_init_n_seen = bus_init_n_seen;
    case (paddr)
      SBAS_CTRL_ADDR, SBAS_STAT_ADDR, SBAS_MON_ADDR, SBAS_CFG_ADDR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    if (wr && hit) begin
      if (paddr == SBAS_CTRL_ADDR) begin
        next_ctl_req = pwdata[SBAS_CTRL_REQ_BIT];
        next_ctl_lock = pwdata[SBAS_CTRL_LOCK_BIT];
        next_ctl_err = pwdata[SBAS_CTRL_ERR_BIT];
        next_ctl_rdy = pwdata[SBAS_CTRL_RDY_BIT];
        next_ctl_bsel = pwdata[SBAS_CTRL_BSEL_LSB +: 2];
        next_ctl_stall = pwdata[SBAS_CTRL_STALL_BIT];
      end else if (paddr == SBAS_MON_ADDR) begin
        next_mon_out = pwdata[3:0];
      end
    end
    if (rd || wr) begin
      next_pslverr = !hit;
    end
    if (rd) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        SBAS_CTRL_ADDR: begin
          // Error bit is a write-only pulse and reads back as zero
          next_prdata[SBAS_CTRL_REQ_BIT] = ctl_req;
          next_prdata[SBAS_CTRL_LOCK_BIT] = ctl_lock;
          next_prdata[SBAS_CTRL_RDY_BIT] = ctl_rdy;
          next_prdata[SBAS_CTRL_BSEL_LSB +: 2] = ctl_bsel;
          next_prdata[SBAS_CTRL_STALL_BIT] = ctl_stall;
        end
        SBAS_STAT_ADDR: begin
          next_prdata[SBAS_STAT_OWN_BIT] = (arb == SBAS_ARB_OWN);
          next_prdata[SBAS_STAT_BUS_INIT_N_BIT] = bus_init_n_seen;
          next_prdata[SBAS_STAT_PRI_BIT] = pri_q;
          next_prdata[SBAS_STAT_BNR_BIT] = bnr_q;
          next_prdata[SBAS_STAT_PROBE_REQUEST_N_BIT] = probe_request_n_q;
          next_prdata[SBAS_STAT_AGENT0_BIT] = agent0;
          next_prdata[SBAS_STAT_ISSUE_BIT] = issue;
          next_prdata[SBAS_STAT_DBG_BIT] = dbg;
        end
        SBAS_MON_ADDR: next_prdata = {28'h0, mon_out};
        SBAS_CFG_ADDR: next_prdata = {30'h0, obs_en, drv_en};
        default: next_prdata = 32'h0000_0000;
      endcase
      // Reading status clears the sticky bus-init flag; a new event wins
      if (paddr == SBAS_STAT_ADDR) next_bus_init_n_seen = 1'b0;
    end

    // Bus-init drive: a fixed-length pulse on a software-reported fault
    next_bus_init_n_cnt = bus_init_n_cnt;
    if (ctl_err && drv_en && bus_init_n_cnt == 2'h0) begin
      next_bus_init_n_cnt = 2'(SBAS_BUS_INIT_N_CYC);
    end else if (bus_init_n_cnt != 2'h0) begin
      next_bus_init_n_cnt = bus_init_n_cnt - 2'h1;
    end

    // Arbitration; queue and tracking state live outside and are untouched
    next_arb = arb;
    case (arb)
      SBAS_ARB_IDLE: if (ctl_req) next_arb = SBAS_ARB_REQ;
      SBAS_ARB_REQ: if (bus_grant_idle && !pri_q) next_arb = SBAS_ARB_OWN;
      SBAS_ARB_OWN: if (!ctl_req) next_arb = SBAS_ARB_IDLE;
      default: next_arb = SBAS_ARB_IDLE;
    endcase
    if (bus_init_n_q && obs_en) begin
      // Lock dropped; pending request re-arbitrates from scratch
      next_bus_init_n_seen = 1'b1;
      next_arb = ctl_req ? SBAS_ARB_REQ : SBAS_ARB_IDLE;
      next_ctl_lock = 1'b0;
    end

    // Issue only as owner, never during stall or foreign priority unless locked
    next_issue = (arb == SBAS_ARB_OWN) && !bnr_q && (!pri_q || ctl_lock);
    next_dbg = probe_request_n_q || (dbg && !ctl_rdy);
  end

  // Pin drivers; bus-init and block-next-request are open-drain style, their data side only ever drives low
  logic next_bus_init_n_oe, next_block_next_request_n_oe;
  logic next_symmetric_request_n_out, next_symmetric_request_n_oe;
  logic [MON_W-1:0] next_breakpoint_monitor_n_out, next_breakpoint_monitor_n_oe;
  always_comb begin
    next_bus_init_n_oe = (next_bus_init_n_cnt != 2'h0);
    next_block_next_request_n_oe = next_ctl_stall;
    next_symmetric_request_n_out = (next_arb == SBAS_ARB_IDLE);
    // Held off until the id strap has been taken, so the strap is not overdriven
    next_symmetric_request_n_oe = cfg_done;
    // Line 4 low means ready; line 5 is input only
    next_breakpoint_monitor_n_out = {1'b1, !next_dbg, ~next_mon_out};
    next_breakpoint_monitor_n_oe = 6'h1F;
  end

  // Every pin is a flop fed by the next values above, except the bus-init and block-next-request data outputs, which load zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_init_n_out <= 1'b1;
      bus_init_n_oe <= 1'b0;
      block_next_request_n_out <= 1'b1;
      block_next_request_n_oe <= 1'b0;
      symmetric_request_n_out <= 1'b1;
      symmetric_request_n_oe <= 1'b0;
      txn_issue <= 1'b0;
      breakpoint_monitor_n_out <= 6'h3F;
      breakpoint_monitor_n_oe <= 6'h00;
      debug_mode <= 1'b0;
      bus_frequency_select <= SBAS_BSEL_RST;
    end else if (clk_en) begin
      bus_init_n_out <= 1'b0;
      bus_init_n_oe <= next_bus_init_n_oe;
      block_next_request_n_out <= 1'b0;
      block_next_request_n_oe <= next_block_next_request_n_oe;
      symmetric_request_n_out <= next_symmetric_request_n_out;
      symmetric_request_n_oe <= next_symmetric_request_n_oe;
      txn_issue <= next_issue;
      breakpoint_monitor_n_out <= next_breakpoint_monitor_n_out;
      breakpoint_monitor_n_oe <= next_breakpoint_monitor_n_oe;
      debug_mode <= next_dbg;
      bus_frequency_select <= next_ctl_bsel;
    end
  end
endmodule // sbas_top

/* tb/sbas_far_agent.sv */
`timescale 1ns/1ps
module sbas_far_agent (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pri_cmd,
  input wire logic bnr_cmd,
  input wire logic probe_request_n_cmd,
  input wire logic bus_init_n_oe,
  input wire logic block_next_request_n_out,
  input wire logic block_next_request_n_oe,
  input wire logic symmetric_request_n_out,
  input wire logic symmetric_request_n_oe,
  input wire logic [5:0] breakpoint_monitor_n_out,
  input wire logic [5:0] breakpoint_monitor_n_oe,
  output logic bus_init_n_in,
  output logic block_next_request_n_in,
  output logic priority_agent_request_n,
  output logic symmetric_request_n_in,
  output logic [5:0] breakpoint_monitor_n_in
);
  logic strap_done;
  // Strap holds the request line low up to the first edge after reset, where the id is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done <= 1'h0;
    end else begin
      strap_done <= 1'h1;
    end
  end
  // Terminated lines float high unless an agent pulls them low
  assign bus_init_n_in = !bus_init_n_oe;
  assign block_next_request_n_in = ~bnr_cmd &
    (block_next_request_n_out | ~block_next_request_n_oe);
  assign priority_agent_request_n = !pri_cmd;
  assign symmetric_request_n_in = symmetric_request_n_oe ? symmetric_request_n_out : strap_done;
  assign breakpoint_monitor_n_in = ~{probe_request_n_cmd, 5'h00} &
    (breakpoint_monitor_n_out | ~breakpoint_monitor_n_oe);
endmodule // sbas_far_agent

/* tb/sbas_top_chk.sv */
`timescale 1ns/1ps
module sbas_top_chk
  import sbas_pkg::*;
#(
  parameter int MON_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic bus_init_n_oe,
  input wire logic block_next_request_n_in,
  input wire logic txn_issue,
  input wire logic [MON_W-1:0] breakpoint_monitor_n_in,
  input wire logic [MON_W-1:0] breakpoint_monitor_n_out,
  input wire logic [MON_W-1:0] breakpoint_monitor_n_oe,
  input wire logic debug_mode,
  input wire logic [1:0] bus_frequency_select
);
  logic ctrl_wr, mon_wr, err_wr;
  assign ctrl_wr = psel && penable && pready && pwrite && paddr == SBAS_CTRL_ADDR;
  assign mon_wr = psel && penable && pready && pwrite && paddr == SBAS_MON_ADDR;
  assign err_wr = ctrl_wr && pwdata[SBAS_CTRL_ERR_BIT];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Fixed length, so a driver that never lets go fails at the release step
  sequence bus_init_n_pulse_s;
    bus_init_n_oe [*2] ##1 !bus_init_n_oe;
  endsequence
  sequence stalled_s;
    !block_next_request_n_in [*6];
  endsequence
  bus_init_n_len_a: assert property ($rose(bus_init_n_oe) |-> bus_init_n_pulse_s)
    else $error("bus-init pulse length wrong");
  bus_init_n_cause_a: assert property (
    $rose(bus_init_n_oe) |-> $past(err_wr) || $past(err_wr, 2))
    else $error("bus-init without error write");
  stall_hold_a: assert property (stalled_s |=> !txn_issue)
    else $error("issue during stall");
  probe_ready_a: assert property (
    $rose(debug_mode) |-> ##[0:2] (breakpoint_monitor_n_oe[4] && !breakpoint_monitor_n_out[4]))
    else $error("probe ready not shown");
  probe_input_a: assert property (!breakpoint_monitor_n_oe[5])
    else $error("probe request line driven");
  probe_req_a: assert property (!breakpoint_monitor_n_in[5] [*8] |-> debug_mode)
    else $error("probe request ignored");
  bsel_write_a: assert property (
    $changed(bus_frequency_select) |-> ctrl_wr)
    else $error("bus select changed alone");
  mon_write_a: assert property (
    $changed(breakpoint_monitor_n_out[3:0]) |-> mon_wr)
    else $error("monitor output changed alone");
endmodule // sbas_top_chk

bind sbas_top sbas_top_chk #(.MON_W(MON_W)) u_sbas_top_chk (.*);

/* tb/test_sbas_top.sv */
`timescale 1ns/1ps
module test_sbas_top
  import sbas_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0, penable = 1'h0, err;
  logic pwrite = 1'h0, bus_grant_idle = 1'h0, pri_cmd = 1'h0, bnr_cmd = 1'h0, probe_request_n_cmd = 1'h0;
  logic cfg_bus_init_n_drive_en = 1'h1, cfg_bus_init_n_observe_en = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, bus_init_n_in, bus_init_n_out, bus_init_n_oe, txn_issue, debug_mode;
  logic block_next_request_n_in, block_next_request_n_out, block_next_request_n_oe;
  logic symmetric_request_n_in, symmetric_request_n_out, symmetric_request_n_oe;
  logic priority_agent_request_n;
  logic [5:0] breakpoint_monitor_n_in, breakpoint_monitor_n_out, breakpoint_monitor_n_oe;
  logic [1:0] bus_frequency_select;
  int fails = 0, comparisons = 0;
  sbas_top u_sbas_top (.*);
  sbas_far_agent u_sbas_far_agent (.*);
  initial forever #25 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic seen;
    n = 0;
    seen = 1'h0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Look at settled values; the next rising edge is the one that samples pready high
    do begin
      @(negedge pclk);
      n++;
      seen = (pready === 1'h1);
    end while (!seen && n < 20);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    chk({31'h0, seen}, 32'h1);
  endtask
  task automatic stop_test();
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    cfg_bus_init_n_drive_en <= 1'h0;
    cfg_bus_init_n_observe_en <= 1'h0;
    apb(1'h0, SBAS_CFG_ADDR, 32'h0);
    chk(rd & 32'h3, 32'h3);
    bus_grant_idle <= 1'h1;
    apb(1'h1, SBAS_CTRL_ADDR, 32'h1);
    repeat (8) @(posedge pclk);
    apb(1'h0, SBAS_STAT_ADDR, 32'h0);
    chk(rd & 32'h61, 32'h61);
    chk({30'h0, symmetric_request_n_oe, symmetric_request_n_out}, 32'h2);
    bnr_cmd <= 1'h1;
    repeat (8) @(posedge pclk);
    chk({31'h0, txn_issue}, 32'h0);
    bnr_cmd <= 1'h0;
    apb(1'h1, SBAS_CTRL_ADDR, 32'h41);
    repeat (8) @(posedge pclk);
    chk({29'h0, block_next_request_n_out, block_next_request_n_oe, txn_issue}, 32'h2);
    apb(1'h1, SBAS_CTRL_ADDR, 32'h3);
    pri_cmd <= 1'h1;
    repeat (8) @(posedge pclk);
    chk({31'h0, txn_issue}, 32'h1);
    apb(1'h1, SBAS_CTRL_ADDR, 32'h1);
    repeat (8) @(posedge pclk);
    chk({31'h0, txn_issue}, 32'h0);
    pri_cmd <= 1'h0;
    apb(1'h1, SBAS_CTRL_ADDR, 32'h7);
    repeat (12) @(posedge pclk);
    apb(1'h0, SBAS_STAT_ADDR, 32'h0);
    chk(rd & 32'h43, 32'h43);
    apb(1'h0, SBAS_STAT_ADDR, 32'h0);
    chk(rd & 32'h2, 32'h0);
    apb(1'h0, SBAS_CTRL_ADDR, 32'h0);
    chk(rd & 32'h3, 32'h1);
    probe_request_n_cmd <= 1'h1;
    repeat (8) @(posedge pclk);
    chk({30'h0, debug_mode, breakpoint_monitor_n_in[4]}, 32'h2);
    probe_request_n_cmd <= 1'h0;
    repeat (8) @(posedge pclk);
    apb(1'h1, SBAS_CTRL_ADDR, 32'h9);
    repeat (4) @(posedge pclk);
    chk({31'h0, debug_mode}, 32'h0);
    apb(1'h1, SBAS_MON_ADDR, 32'h5);
    apb(1'h1, SBAS_CTRL_ADDR, 32'h21);
    repeat (3) @(posedge pclk);
    chk({28'h0, breakpoint_monitor_n_in[3:0]}, 32'hA);
    chk({30'h0, bus_frequency_select}, 32'h2);
    apb(1'h0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // Second reset: observation off, so a bus-init pulse must leave lock and arbitration alone
    presetn <= 1'h0;
    cfg_bus_init_n_observe_en <= 1'h0;
    cfg_bus_init_n_drive_en <= 1'h1;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    apb(1'h0, SBAS_CFG_ADDR, 32'h0);
    chk(rd & 32'h3, 32'h1);
    apb(1'h1, SBAS_CTRL_ADDR, 32'h7);
    @(negedge pclk);
    chk({30'h0, bus_init_n_oe, bus_init_n_out}, 32'h2);
    repeat (12) @(posedge pclk);
    apb(1'h0, SBAS_STAT_ADDR, 32'h0);
    chk(rd & 32'h63, 32'h61);
    apb(1'h0, SBAS_CTRL_ADDR, 32'h0);
    chk(rd & 32'h3, 32'h3);
    stop_test();
  end
  initial begin
    #100000;
    fails++;
    stop_test();
  end
endmodule // test_sbas_top
